//--- blcc_pkg.sv
// shared constants for black level calibration control
package blcc_pkg;

  localparam int NUM_COLOURS = 4;
  localparam int GAIN_W      = 8;
  localparam int LEVEL_W     = 10;
  localparam int THR_W       = 8;
  localparam int OFS_W       = 9;
  localparam int ADDR_W      = 8;
  localparam int DATA_W      = 16;

  localparam logic [ADDR_W-1:0] BTC_ADDR = 8'h5F;
  localparam logic [ADDR_W-1:0] BCC_ADDR = 8'h62;

  localparam logic [DATA_W-1:0] BTC_RESET = 16'h0500;
  localparam logic [DATA_W-1:0] BTC_WMASK = 16'hFFBF;
  localparam logic [DATA_W-1:0] BCC_RESET = 16'h07F8;
  localparam logic [DATA_W-1:0] BCC_WMASK = 16'hEFFF;

  localparam int BTC_INDEP_BIT = 15;
  localparam int BTC_HI_MSB    = 14;
  localparam int BTC_HI_LSB    = 8;
  localparam int BTC_OVR_BIT   = 7;
  localparam int BTC_LO_MSB    = 5;
  localparam int BTC_LO_LSB    = 0;

  localparam int BCC_SWEEP_DIS_BIT = 15;
  localparam int BCC_RESTART_BIT   = 12;
  localparam int BCC_KEEP_BIT      = 11;
  localparam int BCC_APPLY_MSB     = 2;
  localparam int BCC_APPLY_LSB     = 1;
  localparam int BCC_MANUAL_BIT    = 0;

  localparam logic [THR_W-1:0]   HI_MARGIN     = 8'h05;
  localparam logic [THR_W-1:0]   JUMP_MARGIN   = 8'h02;
  localparam logic [LEVEL_W-1:0] MID_MARGIN    = 10'h004;
  localparam logic [LEVEL_W-1:0] BAND_LOW_TOP  = 10'h040;
  localparam logic [LEVEL_W-1:0] BAND_MID_TOP  = 10'h077;
  localparam logic [THR_W-1:0]   HI_CEILING    = 8'h7B;
  localparam int                 GAIN_DIV_SH   = 2;
  localparam logic [8:0]         DARK_PIXELS   = 9'h100;
  localparam int                 AVG_SHIFT     = 8;

endpackage : blcc_pkg

//--- blcc_colour_if.sv
// carrier between the control block and one colour channel
`timescale 1ns/1ps
interface blcc_colour_if;
  logic [blcc_pkg::LEVEL_W-1:0]      pix;
  logic                              pix_valid;
  logic                              frame_done;
  logic                              restart;
  logic                              sweep;
  logic [blcc_pkg::THR_W-1:0]        lo;
  logic [blcc_pkg::THR_W-1:0]        hi;
  logic                              jump;
  logic [blcc_pkg::LEVEL_W-1:0]      jump_level;
  logic [blcc_pkg::LEVEL_W-1:0]      level;
  logic signed [blcc_pkg::OFS_W-1:0] offset;

  modport ctrl (output pix, pix_valid, frame_done, restart, sweep, lo, hi,
                input  jump, jump_level, level, offset);
  modport colour (input  pix, pix_valid, frame_done, restart, sweep, lo, hi,
                  output jump, jump_level, level, offset);
endinterface : blcc_colour_if

//--- blcc_colour.sv
// per-colour dark average, filter and offset stepping
`timescale 1ns/1ps
module blcc_colour #(
  parameter int FILT_SHIFT = 3
) (
  input  wire logic     mclk_in,
  input  wire logic     resetn_in,
  blcc_colour_if.colour bus
);
  localparam int LW    = blcc_pkg::LEVEL_W;
  localparam int FW    = LW + FILT_SHIFT;
  localparam int SUM_W = LW + blcc_pkg::AVG_SHIFT;
  localparam int OW    = blcc_pkg::OFS_W;

  logic [SUM_W-1:0]    sum_reg;
  logic [8:0]          count_reg;
  logic [FW-1:0]       filt_reg;
  logic [FW-1:0]       filt_next;
  logic [LW-1:0]       avg;
  logic [LW-1:0]       level_old;
  logic [LW-1:0]       level_new;
  logic [LW-1:0]       lo_w;
  logic [LW-1:0]       hi_w;
  logic signed [OW-1:0] offset_reg;
  logic signed [OW-1:0] offset_next;
  logic signed [11:0]  sweep_sum;
  logic                jump_reg;
  logic [LW-1:0]       jump_level_reg;

  function automatic logic signed [OW-1:0] sat(input logic signed [11:0] v);
    if (v > 12'sh0FF) begin
      return 9'sh0FF;
    end else if (v < -12'sh100) begin
      return -9'sh100;
    end
    return v[OW-1:0];
  endfunction : sat

  always_comb begin
    avg       = sum_reg[SUM_W-1:blcc_pkg::AVG_SHIFT];
    lo_w      = {2'h0, bus.lo};
    hi_w      = {2'h0, bus.hi};
    level_old = filt_reg[FW-1:FILT_SHIFT];
    if (bus.restart) begin
      filt_next = {avg, {FILT_SHIFT{1'b0}}};
    end else begin
      filt_next = filt_reg + FW'(avg) - (filt_reg >> FILT_SHIFT);
    end
    level_new = filt_next[FW-1:FILT_SHIFT];
    sweep_sum = 12'(offset_reg) + $signed({4'h0, bus.lo}) / 12'sd2
              + $signed({4'h0, bus.hi}) / 12'sd2 - $signed({2'h0, avg});
    offset_next = offset_reg;
    if (bus.sweep) begin
      offset_next = sat(sweep_sum);
    end else if (level_new < lo_w) begin
      offset_next = sat(12'(offset_reg) + 12'sd1);
    end else if (level_new > hi_w) begin
      offset_next = sat(12'(offset_reg) - 12'sd1);
    end
  end

  // dark pixel accumulation, 256 pixels per frame
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sum_reg   <= '0;
      count_reg <= '0;
    end else if (bus.frame_done) begin
      sum_reg   <= '0;
      count_reg <= '0;
    end else if (bus.pix_valid && count_reg < blcc_pkg::DARK_PIXELS) begin
      sum_reg   <= sum_reg + SUM_W'(bus.pix);
      count_reg <= count_reg + 9'h001;
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      filt_reg   <= '0;
      offset_reg <= '0;
    end else if (bus.frame_done) begin
      filt_reg   <= filt_next;
      offset_reg <= offset_next;
    end
  end

  // upward jump from below the lower to above the upper threshold
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      jump_reg       <= 1'b0;
      jump_level_reg <= '0;
    end else begin
      jump_reg <= bus.frame_done && !bus.restart && level_old < lo_w && level_new > hi_w;
      if (bus.frame_done) begin
        jump_level_reg <= level_new;
      end
    end
  end

  assign bus.jump       = jump_reg;
  assign bus.jump_level = jump_level_reg;
  assign bus.level      = level_old;
  assign bus.offset     = offset_reg;
endmodule : blcc_colour

//--- blcc_ctrl.sv
// black level calibration thresholds, control registers and correction select
// How it works
// - gain-independent: programmed lower, upper reloaded per restart
// - gain-dependent: both thresholds derived automatically
// - upper field is max level, default lower+5
// - override bit forces programmed fields, no adjust
// - lower field is minimum level in codes
// - auto lower: maxgain/4 times bit6+1, bit7+1
// - jump under 64: lower+2+twice excess
// - jump 64 to 119: new level plus 4
// - jump above 119: upper becomes 123
// - restart restores upper unless keep bit set
// - sweep-disable bit suppresses rapid sweep
// - restart bit starts average and sweep, self-clears
// - keep bit stops upper reset after sweep
// - apply field: adc only, always, or off
// - manual bit selects programmed correction values
// - offset steps up below lower, down above upper
// - average 256 dark pixels, filter over frames
// - setting changes restart the filtered average
// - manual values replace per-frame computed values
`timescale 1ns/1ps
module blcc_ctrl #(
  parameter int FILT_SHIFT = 3
) (
  input  wire logic                                                    mclk_in,
  input  wire logic                                                    resetn_in,
  input  wire logic [blcc_pkg::ADDR_W-1:0]                             reg_addr_in,
  input  wire logic [blcc_pkg::DATA_W-1:0]                             reg_wdata_in,
  input  wire logic                                                    reg_wr_in,
  output logic      [blcc_pkg::DATA_W-1:0]                             reg_rdata_out,
  input  wire logic [blcc_pkg::NUM_COLOURS-1:0][blcc_pkg::GAIN_W-1:0]  gain_in,
  input  wire logic                                                    settings_change_in,
  input  wire logic                                                    recalc_in,
  input  wire logic                                                    dark_valid_in,
  input  wire logic [1:0]                                              dark_colour_in,
  input  wire logic [blcc_pkg::LEVEL_W-1:0]                            dark_pixel_in,
  input  wire logic                                                    frame_done_in,
  input  wire logic                                                    adc_active_in,
  input  wire logic [blcc_pkg::NUM_COLOURS-1:0][blcc_pkg::OFS_W-1:0]   manual_value_in,
  output logic      [blcc_pkg::NUM_COLOURS-1:0][blcc_pkg::OFS_W-1:0]   offset_out,
  output logic      [blcc_pkg::NUM_COLOURS-1:0][blcc_pkg::LEVEL_W-1:0] black_level_out,
  output logic                                                         correction_on_out,
  output logic      [blcc_pkg::THR_W-1:0]                              lower_black_threshold_out,
  output logic      [blcc_pkg::THR_W-1:0]                              upper_black_threshold_out,
  output logic                                                         restart_pending_out,
  output logic                                                         sweep_active_out
);
  localparam int NC = blcc_pkg::NUM_COLOURS;
  localparam int TW = blcc_pkg::THR_W;
  localparam int LW = blcc_pkg::LEVEL_W;

  logic [blcc_pkg::DATA_W-1:0] btc_reg;
  logic [blcc_pkg::DATA_W-1:0] bcc_reg;
  logic [blcc_pkg::DATA_W-1:0] rdata_reg;
  logic [TW-1:0]               hi_auto_reg;
  logic [TW-1:0]               hi_auto_next;
  logic                        init_done_reg;
  logic                        restart_pend_reg;
  logic                        correction_on_reg;
  logic [NC-1:0][blcc_pkg::OFS_W-1:0] offset_reg;

  logic          wr_btc;
  logic          wr_bcc;
  logic          restart_req;
  logic          restart_event;
  logic          restart_now;
  logic          indep;
  logic          ovr;
  logic          keep;
  logic          sweep_dis;
  logic          manual;
  logic [1:0]    apply;
  logic [blcc_pkg::GAIN_W-1:0] gmax;
  logic [9:0]    lo_auto_w;
  logic [TW-1:0] lo_auto;
  logic [TW-1:0] lo_sel;
  logic [TW-1:0] hi_sel;
  logic [TW-1:0] hi_field;
  logic [TW:0]   hi_restore_w;
  logic [TW-1:0] hi_restore;
  logic [TW-1:0] hi_band;
  logic [LW+1:0] band_low_w;
  logic          jump_any;
  logic [LW-1:0] jump_lvl;
  logic          corr_enable;

  logic [NC-1:0]                            col_jump;
  logic [NC-1:0][LW-1:0]                    col_jump_level;
  logic [NC-1:0][LW-1:0]                    col_level;
  logic [NC-1:0][blcc_pkg::OFS_W-1:0]       col_offset;

  blcc_colour_if cif[NC] ();

  assign wr_btc        = reg_wr_in && reg_addr_in == blcc_pkg::BTC_ADDR;
  assign wr_bcc        = reg_wr_in && reg_addr_in == blcc_pkg::BCC_ADDR;
  assign restart_req   = wr_bcc && reg_wdata_in[blcc_pkg::BCC_RESTART_BIT];
  assign restart_event = restart_req || settings_change_in || recalc_in;
  assign restart_now   = restart_pend_reg || restart_event;

  assign indep     = btc_reg[blcc_pkg::BTC_INDEP_BIT];
  assign ovr       = btc_reg[blcc_pkg::BTC_OVR_BIT];
  assign hi_field  = {1'b0, btc_reg[blcc_pkg::BTC_HI_MSB:blcc_pkg::BTC_HI_LSB]};
  assign keep      = bcc_reg[blcc_pkg::BCC_KEEP_BIT];
  assign sweep_dis = bcc_reg[blcc_pkg::BCC_SWEEP_DIS_BIT];
  assign manual    = bcc_reg[blcc_pkg::BCC_MANUAL_BIT];
  assign apply     = bcc_reg[blcc_pkg::BCC_APPLY_MSB:blcc_pkg::BCC_APPLY_LSB];

  // control registers; write masks clear BTC bit 6 and BCC restart bit 12, all other bits are stored as written
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      btc_reg <= blcc_pkg::BTC_RESET;
    end else if (wr_btc) begin
      btc_reg <= reg_wdata_in & blcc_pkg::BTC_WMASK;
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bcc_reg <= blcc_pkg::BCC_RESET;
    end else if (wr_bcc) begin
      bcc_reg <= reg_wdata_in & blcc_pkg::BCC_WMASK;
    end
  end

  // read data one cycle after the address
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_reg <= '0;
    end else if (reg_addr_in == blcc_pkg::BTC_ADDR) begin
      rdata_reg <= btc_reg;
    end else if (reg_addr_in == blcc_pkg::BCC_ADDR) begin
      rdata_reg <= bcc_reg;
    end else begin
      rdata_reg <= '0;
    end
  end

  // largest colour gain setting and derived lower threshold
  always_comb begin
    gmax = gain_in[0];
    for (int i = 1; i < NC; i++) begin
      if (gain_in[i] > gmax) begin
        gmax = gain_in[i];
      end
    end
    lo_auto_w = 10'(gmax[blcc_pkg::GAIN_W-1:blcc_pkg::GAIN_DIV_SH])
              << (2'(gmax[6]) + 2'(gmax[7]));
    lo_auto   = lo_auto_w[TW-1:0];
    if (ovr || indep) begin
      lo_sel = {2'h0, btc_reg[blcc_pkg::BTC_LO_MSB:blcc_pkg::BTC_LO_LSB]};
    end else begin
      lo_sel = lo_auto;
    end
  end

  // upper threshold after a restart and after a jump
  always_comb begin
    hi_restore_w = {1'b0, lo_sel} + {1'b0, blcc_pkg::HI_MARGIN};
    if (ovr || indep) begin
      hi_restore = hi_field;
    end else if (hi_restore_w[TW]) begin
      hi_restore = '1;
    end else begin
      hi_restore = hi_restore_w[TW-1:0];
    end
    jump_any = 1'b0;
    jump_lvl = '0;
    for (int i = NC - 1; i >= 0; i--) begin
      if (col_jump[i]) begin
        jump_any = 1'b1;
        jump_lvl = col_jump_level[i];
      end
    end
    band_low_w = {jump_lvl, 1'b0} + (LW+2)'(blcc_pkg::JUMP_MARGIN) - (LW+2)'(lo_sel);
    if (jump_lvl < blcc_pkg::BAND_LOW_TOP) begin
      hi_band = band_low_w[TW-1:0];
    end else if (jump_lvl <= blcc_pkg::BAND_MID_TOP) begin
      hi_band = TW'(jump_lvl + blcc_pkg::MID_MARGIN);
    end else begin
      hi_band = blcc_pkg::HI_CEILING;
    end
    hi_auto_next = hi_auto_reg;
    if (!init_done_reg || (restart_event && !keep)) begin
      hi_auto_next = hi_restore;
    end else if (jump_any && !ovr) begin
      hi_auto_next = hi_band;
    end
    if (ovr) begin
      hi_sel = hi_field;
    end else begin
      hi_sel = hi_auto_reg;
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hi_auto_reg   <= blcc_pkg::HI_MARGIN;
      init_done_reg <= 1'b0;
    end else begin
      hi_auto_reg   <= hi_auto_next;
      init_done_reg <= 1'b1;
    end
  end

  // restart pending until the next dark-row frame end; a new request wins
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      restart_pend_reg <= 1'b0;
    end else if (restart_event) begin
      restart_pend_reg <= 1'b1;
    end else if (frame_done_in) begin
      restart_pend_reg <= 1'b0;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NC; g++) begin : gen_colour
      assign cif[g].pix        = dark_pixel_in;
      assign cif[g].pix_valid  = dark_valid_in && dark_colour_in == 2'(g);
      assign cif[g].frame_done = frame_done_in;
      assign cif[g].restart    = restart_now;
      assign cif[g].sweep      = restart_now && !sweep_dis;
      assign cif[g].lo         = lo_sel;
      assign cif[g].hi         = hi_sel;
      assign col_jump[g]       = cif[g].jump;
      assign col_jump_level[g] = cif[g].jump_level;
      assign col_level[g]      = cif[g].level;
      assign col_offset[g]     = cif[g].offset;

      blcc_colour #(
        .FILT_SHIFT (FILT_SHIFT)
      ) u_colour (
        .mclk_in   (mclk_in),
        .resetn_in (resetn_in),
        .bus       (cif[g].colour)
      );
    end
  endgenerate

  assign corr_enable = !apply[0] && (apply[1] || adc_active_in);

  // correction value per colour, zero when disabled
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      offset_reg        <= '0;
      correction_on_reg <= 1'b0;
    end else begin
      correction_on_reg <= corr_enable;
      for (int i = 0; i < NC; i++) begin
        if (!corr_enable) begin
          offset_reg[i] <= '0;
        end else if (manual) begin
          offset_reg[i] <= manual_value_in[i];
        end else begin
          offset_reg[i] <= col_offset[i];
        end
      end
    end
  end

  assign reg_rdata_out             = rdata_reg;
  assign offset_out                = offset_reg;
  assign black_level_out           = col_level;
  assign correction_on_out         = correction_on_reg;
  assign lower_black_threshold_out = lo_sel;
  assign upper_black_threshold_out = hi_sel;
  assign restart_pending_out       = restart_pend_reg;
  assign sweep_active_out          = restart_pend_reg && !sweep_dis;
endmodule : blcc_ctrl

//--- blcc_ctrl_props.sv
// concurrent property checker for the black level calibration control block
`timescale 1ns/1ps
module blcc_ctrl_props (
  input wire logic                                                  mclk_in,
  input wire logic                                                  resetn_in,
  input wire logic [blcc_pkg::ADDR_W-1:0]                           reg_addr_in,
  input wire logic [blcc_pkg::DATA_W-1:0]                           reg_wdata_in,
  input wire logic                                                  reg_wr_in,
  input wire logic [blcc_pkg::DATA_W-1:0]                           reg_rdata_out,
  input wire logic                                                  settings_change_in,
  input wire logic                                                  recalc_in,
  input wire logic                                                  frame_done_in,
  input wire logic [blcc_pkg::NUM_COLOURS-1:0][blcc_pkg::OFS_W-1:0] offset_out,
  input wire logic                                                  correction_on_out,
  input wire logic [blcc_pkg::THR_W-1:0]                            lower_black_threshold_out,
  input wire logic [blcc_pkg::THR_W-1:0]                            upper_black_threshold_out,
  input wire logic                                                  restart_pending_out,
  input wire logic                                                  sweep_active_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  logic wr_btc;
  logic wr_bcc;
  assign wr_btc = reg_wr_in && (reg_addr_in == blcc_pkg::BTC_ADDR);
  assign wr_bcc = reg_wr_in && (reg_addr_in == blcc_pkg::BCC_ADDR);

  restart_set_a: assert property (wr_bcc && reg_wdata_in[12] |=> restart_pending_out &&
    (sweep_active_out != $past(reg_wdata_in[15]))) else $error("restart write not taken");
  event_set_a: assert property (settings_change_in || recalc_in |=> restart_pending_out)
    else $error("restart event not taken");
  pend_clear_a: assert property (frame_done_in && !settings_change_in && !recalc_in &&
    !(wr_bcc && reg_wdata_in[12]) |=> !restart_pending_out) else $error("pending not cleared");
  sweep_gate_a: assert property (sweep_active_out |-> restart_pending_out)
    else $error("sweep without restart");
  unmapped_read_a: assert property ((reg_addr_in != blcc_pkg::BTC_ADDR) && (reg_addr_in != blcc_pkg::BCC_ADDR)
    |=> reg_rdata_out == '0) else $error("unmapped read not zero");
  self_clear_a: assert property (reg_addr_in == blcc_pkg::BCC_ADDR |=> !reg_rdata_out[12])
    else $error("restart bit reads one");
  override_thr_a: assert property (wr_btc && reg_wdata_in[7] |=>
    lower_black_threshold_out == {2'b00, $past(reg_wdata_in[5:0])} &&
    upper_black_threshold_out == {1'b0, $past(reg_wdata_in[14:8])}) else $error("override thresholds wrong");
  indep_lo_a: assert property (wr_btc && reg_wdata_in[15] |=>
    lower_black_threshold_out == {2'b00, $past(reg_wdata_in[5:0])}) else $error("independent lower wrong");
  apply_off_a: assert property (wr_bcc && reg_wdata_in[1] ##1 !wr_bcc |=> !correction_on_out)
    else $error("correction not disabled");
  apply_cont_a: assert property (wr_bcc && reg_wdata_in[2:1] == 2'b10 ##1 !wr_bcc |=> correction_on_out)
    else $error("continuous correction off");
  offset_zero_a: assert property (wr_bcc && reg_wdata_in[1] ##1 !wr_bcc [*2] |=> offset_out == '0)
    else $error("offset not forced to zero");

  restart_c: cover property (wr_bcc && reg_wdata_in[12]);
  override_c: cover property (wr_btc && reg_wdata_in[7]);
  disable_c: cover property (wr_bcc && reg_wdata_in[1]);
endmodule : blcc_ctrl_props

bind blcc_ctrl blcc_ctrl_props u_props (.mclk_in(mclk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rdata_out(reg_rdata_out),
  .settings_change_in(settings_change_in), .recalc_in(recalc_in), .frame_done_in(frame_done_in),
  .offset_out(offset_out), .correction_on_out(correction_on_out),
  .lower_black_threshold_out(lower_black_threshold_out), .upper_black_threshold_out(upper_black_threshold_out),
  .restart_pending_out(restart_pending_out), .sweep_active_out(sweep_active_out));

//--- blcc_ctrl_test.sv
// self-checking testbench for the black level calibration control block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin fail_count++; \
  $display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end
module blcc_ctrl_test;
  logic                                                  mclk_in = 1'b0;
  logic                                                  resetn_in = 1'b0;
  logic [7:0]                                            reg_addr_in = 8'h00;
  logic [15:0]                                           reg_wdata_in = 16'h0000;
  logic                                                  reg_wr_in = 1'b0;
  logic [15:0]                                           reg_rdata_out;
  logic [blcc_pkg::NUM_COLOURS-1:0][blcc_pkg::GAIN_W-1:0] gain_in = '0;
  logic                                                  settings_change_in = 1'b0;
  logic                                                  recalc_in = 1'b0;
  logic                                                  frame_done_in = 1'b0;
  logic                                                  adc_active_in = 1'b0;
  logic                                                  dark_valid_in = 1'b0;
  logic [1:0]                                            dark_colour_in = 2'b00;
  logic [blcc_pkg::LEVEL_W-1:0]                          dark_pixel_in = '0;
  logic [blcc_pkg::NUM_COLOURS-1:0][blcc_pkg::OFS_W-1:0] manual_value_in = '0;
  logic [blcc_pkg::NUM_COLOURS-1:0][blcc_pkg::OFS_W-1:0] offset_out;
  logic [blcc_pkg::NUM_COLOURS-1:0][blcc_pkg::LEVEL_W-1:0] black_level_out;
  logic                                                  correction_on_out;
  logic [7:0]                                            lower_black_threshold_out;
  logic [7:0]                                            upper_black_threshold_out;
  logic                                                  restart_pending_out;
  logic                                                  sweep_active_out;
  int                                                    fail_count = 0;
  int                                                    comparisons = 0;

  blcc_ctrl uut (.mclk_in(mclk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rdata_out(reg_rdata_out), .gain_in(gain_in), .settings_change_in(settings_change_in),
    .recalc_in(recalc_in), .dark_valid_in(dark_valid_in), .dark_colour_in(dark_colour_in),
    .dark_pixel_in(dark_pixel_in),
    .frame_done_in(frame_done_in), .adc_active_in(adc_active_in), .manual_value_in(manual_value_in),
    .offset_out(offset_out), .black_level_out(black_level_out), .correction_on_out(correction_on_out),
    .lower_black_threshold_out(lower_black_threshold_out), .upper_black_threshold_out(upper_black_threshold_out),
    .restart_pending_out(restart_pending_out), .sweep_active_out(sweep_active_out));

  always #4 mclk_in = ~mclk_in;

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge mclk_in);
      #1;
    end
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    tick(1);
    reg_wr_in = 1'b0;
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
    reg_addr_in = a;
    tick(1);
    `CHK("read data", exp, reg_rdata_out)
  endtask : rdchk

  // restart event, then one frame end so any sweep and restore complete
  task automatic restart(input bit by_settings);
    if (by_settings) settings_change_in = 1'b1;
    else recalc_in = 1'b1;
    tick(1);
    settings_change_in = 1'b0;
    recalc_in = 1'b0;
    `CHK("pending", 1'b1, restart_pending_out)
    frame_done_in = 1'b1;
    tick(1);
    frame_done_in = 1'b0;
    tick(3);
  endtask : restart

  task automatic thr(input logic [7:0] lo, input logic [7:0] hi);
    `CHK("lower", lo, lower_black_threshold_out)
    `CHK("upper", hi, upper_black_threshold_out)
  endtask : thr

  task automatic t_reset;
    thr(8'h00, 8'h05);
    rdchk(8'h5F, 16'h0500);
    rdchk(8'h62, 16'h07F8);
    wr(8'h30, 16'hFFFF);
    rdchk(8'h30, 16'h0000);
    rdchk(8'h5F, 16'h0500);
  endtask : t_reset

  task automatic t_auto_keep;
    gain_in = {8'h10, 8'h51, 8'h08, 8'h20};
    tick(1);
    thr(8'h28, 8'h05);
    restart(1'b1);
    thr(8'h28, 8'h2D);
    wr(8'h62, 16'h0FF8);
    gain_in[3] = 8'hC4;
    restart(1'b1);
    thr(8'hC4, 8'h2D);
    wr(8'h62, 16'h07F8);
    restart(1'b0);
    thr(8'hC4, 8'hC9);
  endtask : t_auto_keep

  task automatic t_restart;
    wr(8'h62, 16'h17F8);
    `CHK("pending", 1'b1, restart_pending_out)
    `CHK("sweep", 1'b1, sweep_active_out)
    rdchk(8'h62, 16'h07F8);
    frame_done_in = 1'b1;
    tick(1);
    frame_done_in = 1'b0;
    tick(1);
    `CHK("pending", 1'b0, restart_pending_out)
    wr(8'h62, 16'h97F8);
    `CHK("sweep", 1'b0, sweep_active_out)
    rdchk(8'h62, 16'h87F8);
    wr(8'h62, 16'h07F8);
    restart(1'b0);
  endtask : t_restart

  task automatic t_override;
    wr(8'h5F, 16'h32D4);
    thr(8'h14, 8'h32);
    rdchk(8'h5F, 16'h3294);
    restart(1'b0);
    thr(8'h14, 8'h32);
    wr(8'h5F, 16'hA80A);
    `CHK("lower", 8'h0A, lower_black_threshold_out)
    restart(1'b0);
    thr(8'h0A, 8'h28);
  endtask : t_override

  task automatic t_apply;
    for (int c = 0; c < 4; c++) begin
      for (int a = 0; a < 2; a++) begin
        wr(8'h62, 16'h07F8 | 16'(c << 1));
        adc_active_in = a[0];
        tick(3);
        `CHK("correction on", 1'((c == 0) ? a : (c == 2)), correction_on_out)
      end
    end
    manual_value_in = {9'h1F0, 9'h055, 9'h100, 9'h0FF};
    wr(8'h62, 16'h07FD);
    restart(1'b0);
    `CHK("manual offsets", manual_value_in, offset_out)
    wr(8'h62, 16'h07FB);
    tick(3);
    `CHK("disabled offsets", 36'h0, offset_out)
  endtask : t_apply

  // levels cleared by a restart, then one frame of colour 0 pixels jumps above the upper threshold
  task automatic t_jump(input logic [9:0] pix, input logic [9:0] lvl, input logic [7:0] hi);
    logic [8:0] prev;
    wr(8'h62, 16'h07FC);
    restart(1'b0);
    dark_pixel_in = pix;
    dark_valid_in = 1'b1;
    tick(256);
    dark_valid_in = 1'b0;
    prev = offset_out[0];
    frame_done_in = 1'b1;
    tick(1);
    frame_done_in = 1'b0;
    tick(3);
    `CHK("black level", lvl, black_level_out[0])
    `CHK("upper", hi, upper_black_threshold_out)
    `CHK("offset step", 9'(prev - 9'h001), offset_out[0])
  endtask : t_jump

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  // watchdog: the sequence needs well under 1500 cycles
  initial begin
    #20000;
    fail_count++;
    stop_test();
  end

  initial begin
    repeat (3) @(posedge mclk_in);
    #1;
    resetn_in = 1'b1;
    tick(1);
    t_reset();
    t_auto_keep();
    t_restart();
    t_override();
    t_apply();
    t_jump(10'h190, 10'h032, 8'h5C);
    t_jump(10'h320, 10'h064, 8'h68);
    t_jump(10'h3C0, 10'h078, 8'h7B);
    stop_test();
  end
endmodule : blcc_ctrl_test
